// file: pkg/two_wire_pkg.sv
// Purpose: Shared constants of the two-wire bus controller
// Assumes: Byte-wide register port, 100 MHz module clock
// Notes: Offsets 0x6..0x8 hold the interrupt status, enable and clear registers
package two_wire_pkg;

  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFF_SERIAL_DATA = 4'h0;
  localparam logic [3:0] OFF_BUS_STATUS = 4'h1;
  localparam logic [3:0] OFF_CONTROL_STATUS = 4'h2;
  localparam logic [3:0] OFF_CONTROL_ONE = 4'h3;
  localparam logic [3:0] OFF_OWN_SLAVE_ADDRESS = 4'h4;
  localparam logic [3:0] OFF_CONTROL_TWO = 4'h5;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h6;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h7;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'h8;

  // bus_status fields
  localparam int BS_SLAVE_STOP = 7;
  localparam int BS_NEW_MATCH = 2;
  localparam int BS_MASTER = 1;
  // control_status fields
  localparam int CS_MATCH = 2;
  localparam int CS_BUS_BUSY = 1;
  localparam int CS_BUSY = 0;
  // control_one fields
  localparam int C1_NEW_HIT_IRQ_ON = 6;
  localparam int C1_ACK = 4;
  localparam int C1_RESERVED = 3;
  localparam int C1_UNIT_IRQ_ON = 2;
  localparam int C1_STOP = 1;
  localparam int C1_START = 0;
  // own_slave_address fields
  localparam int OA_CHECK_ON = 7;
  localparam int OWN_ADDR_W = 7;
  // control_two_clock_divider fields
  localparam int C2_DIV_MSB = 7;
  localparam int C2_DIV_LSB = 1;
  localparam int C2_ENABLE = 0;
  localparam int DIV_W = 7;
  localparam int DIV_MIN = 8;
  localparam int DIV_MAX = 127;

  // Interrupt status layout
  localparam int IRQ_W = 3;
  localparam int IRQ_NEW_HIT = 0;
  localparam int IRQ_SLAVE_STOP = 1;
  localparam int IRQ_BYTE_DONE = 2;

  // Reset values and counts
  localparam logic [7:0] REG_CLEARED = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_CLEARED = 3'h0;
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam int HALF_PERIOD_MULT = 2;
  localparam int CLK_PERIOD_NS = 10;

endpackage : two_wire_pkg

// file: verilog/scl_half_period_gen.sv
// Purpose: SCL level generator for master mode, counting module clocks
// Assumes: divider steady while run is high
// Notes: Level idles high; each level lasts HALF_PERIOD_MULT * divider cycles
`timescale 1ns/1ps
module scl_half_period_gen #(
  parameter int DIV_W = two_wire_pkg::DIV_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [DIV_W-1:0] divider,
  output logic sclHigh,
  output logic sclEdge
);

  localparam int CNT_W = DIV_W + 1;

  if (DIV_W < 4 || DIV_W > 15)
  begin : g_badWidth
    $error("scl_half_period_gen: DIV_W out of range");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] reloadValue;
  logic [CNT_W-1:0] sinceEdge_reg;

  assign reloadValue = CNT_W'({divider, 1'b0}) - CNT_W'(1);
  assign sclEdge = run && (cnt_reg == '0);

  // Reload at every SCL edge so each level is a full count
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      sclHigh <= 1'b1;
    end
    else if (!run)
    begin
      cnt_reg <= reloadValue;
      sclHigh <= 1'b1;
    end
    else if (cnt_reg == '0)
    begin
      cnt_reg <= reloadValue;
      sclHigh <= ~sclHigh;
    end
    else
    begin
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sinceEdge_reg <= '0;
    else if (!run || sclEdge)
      sinceEdge_reg <= '0;
    else
      sinceEdge_reg <= sinceEdge_reg + CNT_W'(1);
  end

  property p_halfPeriod;
    @(posedge clk_sys) disable iff (rst)
      (sclEdge && $stable(divider)) |->
        (sinceEdge_reg == CNT_W'(two_wire_pkg::HALF_PERIOD_MULT * divider - 1));
  endproperty
  a_halfPeriod: assert property (p_halfPeriod) else $error("SCL level length wrong");

  property p_edgeToggles;
    @(posedge clk_sys) disable iff (rst)
      (sclEdge && $past(run)) |=> (sclHigh != $past(sclHigh));
  endproperty
  a_edgeToggles: assert property (p_edgeToggles) else $error("SCL did not toggle");

endmodule : scl_half_period_gen

// file: verilog/two_wire_unit.sv
// Purpose: Two-wire bus controller: own-address match, master SCL, registers
// Assumes: Pins sampled synchronously; open-drain pins driven low only
// Notes:
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module two_wire_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [two_wire_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [two_wire_pkg::REG_DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [two_wire_pkg::REG_DATA_W-1:0] regRdData,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic irq
);

  function automatic logic regHit(input logic strobe, input logic [3:0] addr,
                                  input logic [3:0] offset);
    regHit = strobe && (addr == offset);
  endfunction : regHit

  logic [7:0] serialData_reg;
  logic [7:0] controlOne_reg;
  logic [7:0] ownAddr_reg;
  logic [7:0] controlTwo_reg;
  logic slaveStop_reg;
  logic newMatchFlag_reg;
  logic matchFlag_reg;
  logic busBusy_reg;
  logic [two_wire_pkg::IRQ_W-1:0] irqStatus_reg;
  logic [two_wire_pkg::IRQ_W-1:0] irqEnable_reg;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic addrPhase_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic ackPending_reg;
  logic ackDrive_reg;
  logic masterActive_reg;
  logic masterSdaLow_reg;
  logic stopping_reg;
  logic stopRelease_reg;
  logic enable;
  logic checkOn;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;
  logic compareNow;
  logic newMatch;
  logic issueStart;
  logic stopDone;
  logic slaveStopEvent;
  logic sclRun;
  logic sclHigh;
  logic sclEdge;
  logic [two_wire_pkg::IRQ_W-1:0] irqEvents;
  logic [two_wire_pkg::IRQ_W-1:0] irqGate;

  assign enable = controlTwo_reg[two_wire_pkg::C2_ENABLE];
  assign checkOn = ownAddr_reg[two_wire_pkg::OA_CHECK_ON];

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection, masked off while the unit is disabled
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= sclIn;
      sdaPrev_reg <= sdaIn;
    end
  end

  assign startSeen = enable && sclIn && sclPrev_reg && sdaPrev_reg && !sdaIn;
  assign stopSeen = enable && sclIn && sclPrev_reg && !sdaPrev_reg && sdaIn;
  assign sclRise = enable && sclIn && !sclPrev_reg;
  assign sclFall = enable && !sclIn && sclPrev_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      busBusy_reg <= 1'b0;
    else if (!enable || stopSeen)
      busBusy_reg <= 1'b0;
    else if (startSeen)
      busBusy_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave address reception
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      addrPhase_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end
    else if (!enable || stopSeen)
    begin
      addrPhase_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
    end
    else if (startSeen && !masterActive_reg)
    begin
      addrPhase_reg <= 1'b1;
      bitCnt_reg <= 4'h0;
    end
    else if (addrPhase_reg && sclRise)
    begin
      // Left shift lands the first bit at position six after seven bits
      shift_reg <= {shift_reg[6:0], sdaIn};
      bitCnt_reg <= bitCnt_reg + 4'h1;
      if (bitCnt_reg == two_wire_pkg::ADDR_LAST_BIT)
        addrPhase_reg <= 1'b0;
    end
  end

  // Eighth rising edge: seven address bits held, direction bit on the wire
  assign compareNow = addrPhase_reg && sclRise && (bitCnt_reg == two_wire_pkg::ADDR_LAST_BIT);
  assign newMatch = compareNow && checkOn
                    && (shift_reg[6:0] == ownAddr_reg[6:0]);

  // Acknowledge a match on the ninth clock unless software asked for a NACK
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ackPending_reg <= 1'b0;
      ackDrive_reg <= 1'b0;
    end
    else if (!enable || stopSeen)
    begin
      ackPending_reg <= 1'b0;
      ackDrive_reg <= 1'b0;
    end
    else if (newMatch)
      ackPending_reg <= !controlOne_reg[two_wire_pkg::C1_ACK];
    else if (sclFall)
    begin
      ackDrive_reg <= ackPending_reg;
      ackPending_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master start and stop, SCL from the divider
  assign issueStart = enable && controlOne_reg[two_wire_pkg::C1_START] && !busBusy_reg
                      && !masterActive_reg && !stopping_reg;
  assign stopDone = stopping_reg && sclEdge;
  assign sclRun = enable && (masterActive_reg || stopping_reg);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      masterActive_reg <= 1'b0;
      masterSdaLow_reg <= 1'b0;
      stopping_reg <= 1'b0;
    end
    else if (!enable)
    begin
      masterActive_reg <= 1'b0;
      masterSdaLow_reg <= 1'b0;
      stopping_reg <= 1'b0;
    end
    else if (issueStart)
    begin
      masterActive_reg <= 1'b1;
      masterSdaLow_reg <= 1'b1;
    end
    else if (masterActive_reg && controlOne_reg[two_wire_pkg::C1_STOP] && sclEdge && !sclHigh)
    begin
      // SCL goes high here; SDA rises one level later to form the stop
      masterActive_reg <= 1'b0;
      stopping_reg <= 1'b1;
    end
    else if (stopDone)
    begin
      stopping_reg <= 1'b0;
      masterSdaLow_reg <= 1'b0;
    end
  end

  // Our own stop reaches the wire a cycle after release; keep it out of slave stop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stopRelease_reg <= 1'b0;
    else
      stopRelease_reg <= stopDone;
  end

  assign slaveStopEvent = stopSeen && !masterActive_reg && !stopRelease_reg;

  scl_half_period_gen #(
    .DIV_W(two_wire_pkg::DIV_W)
  ) u_sclGen (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(sclRun),
    .divider(controlTwo_reg[two_wire_pkg::C2_DIV_MSB:two_wire_pkg::C2_DIV_LSB]),
    .sclHigh(sclHigh),
    .sclEdge(sclEdge)
  );

  // Open-drain: only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = sclRun && !sclHigh;
  assign sdaOe = ackDrive_reg || masterSdaLow_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      controlOne_reg <= two_wire_pkg::REG_CLEARED;
    else if (!enable)
      controlOne_reg <= two_wire_pkg::REG_CLEARED;
    else if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_CONTROL_ONE))
    begin
      controlOne_reg <= regWrData;
      controlOne_reg[two_wire_pkg::C1_RESERVED] <= 1'b0;
    end
    else
    begin
      if (issueStart)
        controlOne_reg[two_wire_pkg::C1_START] <= 1'b0;
      if (stopDone)
        controlOne_reg[two_wire_pkg::C1_STOP] <= 1'b0;
    end
  end

  // No reset: software must program the address before matching
  always_ff @(posedge clk_sys)
  begin
    if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_OWN_SLAVE_ADDRESS))
      ownAddr_reg <= regWrData;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      controlTwo_reg <= two_wire_pkg::CONTROL_TWO_RESET;
    else if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_CONTROL_TWO))
      controlTwo_reg <= regWrData;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      serialData_reg <= two_wire_pkg::REG_CLEARED;
    else if (compareNow)
      serialData_reg <= {shift_reg[6:0], sdaIn};
    else if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_SERIAL_DATA))
      serialData_reg <= regWrData;
  end

  // Sticky status: writing one clears slave stop and new match, a same-cycle event wins; match clears on start or stop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      slaveStop_reg <= 1'b0;
      newMatchFlag_reg <= 1'b0;
      matchFlag_reg <= 1'b0;
    end
    else if (!enable)
    begin
      slaveStop_reg <= 1'b0;
      newMatchFlag_reg <= 1'b0;
      matchFlag_reg <= 1'b0;
    end
    else
    begin
      if (slaveStopEvent)
        slaveStop_reg <= 1'b1;
      else if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_BUS_STATUS)
               && regWrData[two_wire_pkg::BS_SLAVE_STOP])
        slaveStop_reg <= 1'b0;
      if (newMatch)
        newMatchFlag_reg <= 1'b1;
      else if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_BUS_STATUS)
               && regWrData[two_wire_pkg::BS_NEW_MATCH])
        newMatchFlag_reg <= 1'b0;
      if (newMatch)
        matchFlag_reg <= 1'b1;
      else if (stopSeen || startSeen)
        matchFlag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  assign irqEvents = {compareNow, slaveStopEvent, newMatch};
  assign irqGate = {2'b11, controlOne_reg[two_wire_pkg::C1_NEW_HIT_IRQ_ON]};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqStatus_reg <= two_wire_pkg::IRQ_CLEARED;
    else if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_IRQ_CLEAR))
      irqStatus_reg <= (irqStatus_reg & ~regWrData[two_wire_pkg::IRQ_W-1:0]) | irqEvents;
    else
      irqStatus_reg <= irqStatus_reg | irqEvents;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqEnable_reg <= two_wire_pkg::IRQ_CLEARED;
    else if (regHit(regWrStrobe, regAddr, two_wire_pkg::OFF_IRQ_ENABLE))
      irqEnable_reg <= regWrData[two_wire_pkg::IRQ_W-1:0];
  end

  assign irq = controlOne_reg[two_wire_pkg::C1_UNIT_IRQ_ON]
               && |(irqStatus_reg & irqEnable_reg & irqGate);

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      regRdData <= two_wire_pkg::REG_CLEARED;
    else if (regRdStrobe)
    begin
      case (regAddr)
        two_wire_pkg::OFF_SERIAL_DATA: regRdData <= serialData_reg;
        two_wire_pkg::OFF_BUS_STATUS:
          regRdData <= {slaveStop_reg, 4'h0, newMatchFlag_reg, masterActive_reg, 1'b0};
        two_wire_pkg::OFF_CONTROL_STATUS:
          regRdData <= {5'h00, matchFlag_reg, busBusy_reg, addrPhase_reg || masterActive_reg};
        two_wire_pkg::OFF_CONTROL_ONE: regRdData <= controlOne_reg;
        two_wire_pkg::OFF_OWN_SLAVE_ADDRESS: regRdData <= ownAddr_reg;
        two_wire_pkg::OFF_CONTROL_TWO: regRdData <= controlTwo_reg;
        two_wire_pkg::OFF_IRQ_STATUS: regRdData <= {5'h00, irqStatus_reg};
        two_wire_pkg::OFF_IRQ_ENABLE: regRdData <= {5'h00, irqEnable_reg};
        default: regRdData <= two_wire_pkg::REG_CLEARED;
      endcase
    end
    else
      regRdData <= two_wire_pkg::REG_CLEARED;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_disabled;
    !enable;
  endsequence

  sequence s_controlCleared;
    ##1 (controlOne_reg == 8'h00 && !slaveStop_reg && !newMatchFlag_reg && !matchFlag_reg);
  endsequence

  property p_disableClears;
    @(posedge clk_sys) disable iff (rst) s_disabled |-> s_controlCleared;
  endproperty
  a_disableClears: assert property (p_disableClears) else $error("Disable left state");

  property p_disableHalts;
    @(posedge clk_sys) disable iff (rst) s_disabled |=> (!sclOe && !masterActive_reg);
  endproperty
  a_disableHalts: assert property (p_disableHalts) else $error("SCL not halted");

  property p_noCheckNoMatch;
    @(posedge clk_sys) disable iff (rst) !checkOn |-> !newMatch;
  endproperty
  a_noCheckNoMatch: assert property (p_noCheckNoMatch) else $error("Match while off");

  property p_matchEqual;
    @(posedge clk_sys) disable iff (rst)
      newMatch |-> (shift_reg[6:0] == ownAddr_reg[6:0] && bitCnt_reg == 4'h7);
  endproperty
  a_matchEqual: assert property (p_matchEqual) else $error("False address match");

  property p_matchFlags;
    @(posedge clk_sys) disable iff (rst)
      newMatch |=> (newMatchFlag_reg && matchFlag_reg && irqStatus_reg[0]);
  endproperty
  a_matchFlags: assert property (p_matchFlags) else $error("Match not flagged");

  property p_firstBitHigh;
    @(posedge clk_sys) disable iff (rst)
      (addrPhase_reg && sclRise && bitCnt_reg == 4'h0) ##1 (!sclRise)[*6]
        |-> (shift_reg[0] == $past(sdaIn, 6));
  endproperty
  a_firstBitHigh: assert property (p_firstBitHigh) else $error("Bit order wrong");

  property p_matchIrqGate;
    @(posedge clk_sys) disable iff (rst)
      (irqStatus_reg == 3'h1 && !controlOne_reg[two_wire_pkg::C1_NEW_HIT_IRQ_ON]) |-> !irq;
  endproperty
  a_matchIrqGate: assert property (p_matchIrqGate) else $error("Match irq ungated");

  property p_readLatency;
    @(posedge clk_sys) disable iff (rst)
      (regRdStrobe && regAddr == two_wire_pkg::OFF_CONTROL_TWO)
        |=> (regRdData == $past(controlTwo_reg));
  endproperty
  a_readLatency: assert property (p_readLatency) else $error("Read data late");

endmodule : two_wire_unit

// file: verification/bus_peer_model.sv
// Purpose: Behavioural outside master on the two-wire bus
// Assumes: Open-drain wires with pull-ups, resolved by the bench
// Notes: One bus level lasts HALF module clocks; lines released read high
`timescale 1ns/1ps
module bus_peer_model #(
  parameter int HALF = 8
) (
  input wire logic clk_sys,
  input wire logic sclWire,
  input wire logic sdaWire,
  output logic sclLow,
  output logic sdaLow
);
  initial
  begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold

  ////////////////////////////////////////////////////////////////////////////////
  // Start, seven address bits with direction, acknowledge clock, stop
  task automatic sendAddr(input logic [7:0] addrByte, output logic acked);
    @(posedge clk_sys);
    sdaLow <= 1'b1;
    hold(HALF);
    for (int i = 7; i >= 0; i--)
    begin
      sclLow <= 1'b1;
      hold(HALF / 2);
      // Data only moves while the clock is low, so no false start or stop
      sdaLow <= ~addrByte[i];
      hold(HALF / 2);
      sclLow <= 1'b0;
      hold(HALF);
    end
    sclLow <= 1'b1;
    sdaLow <= 1'b0;
    hold(HALF);
    sclLow <= 1'b0;
    hold(HALF / 2);
    acked = ~sdaWire;
    hold(HALF / 2);
    sclLow <= 1'b1;
    sdaLow <= 1'b1;
    hold(HALF);
    sclLow <= 1'b0;
    hold(HALF);
    sdaLow <= 1'b0;
    hold(HALF);
  endtask : sendAddr
endmodule : bus_peer_model

// file: verification/two_wire_unit_test.sv
// Purpose: Self-checking bench of the two-wire bus controller
// Assumes: Peer model plays an outside master on the resolved wires
// Notes: Divider runs use both ends of the legal range
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      nFail++; \
      $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
  end

module two_wire_unit_test;
  logic clk_sys, rst, regWrStrobe, regRdStrobe, sclOut, sclOe, sdaOut, sdaOe, irq;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic peerSclLow, peerSdaLow, sclWire, sdaWire, ackd;
  logic [6:0] div;
  int nFail, checks, n;
  logic [7:0] ownTab [5] = '{8'hDA, 8'hDA, 8'hDA, 8'h5A, 8'hA5};
  logic [7:0] sentTab [5] = '{8'hB4, 8'h34, 8'hB6, 8'hB4, 8'h4B};
  logic hitTab [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [3:0] resetOffs [5] = '{4'h5, 4'h3, 4'h1, 4'h6, 4'hF};

  // Pull-ups: a wire is low only while some party drives it
  assign sclWire = (sclOe ? sclOut : 1'b1) & ~peerSclLow;
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~peerSdaLow;

  two_wire_unit two_wire_unit_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe),
    .regRdData(regRdData),
    .sclIn(sclWire),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaIn(sdaWire),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .irq(irq)
  );

  bus_peer_model #(.HALF(8)) bus_peer_model_i (
    .clk_sys(clk_sys),
    .sclWire(sclWire),
    .sdaWire(sdaWire),
    .sclLow(peerSclLow),
    .sdaLow(peerSdaLow)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk_sys);
    regWrStrobe <= 1'b0;
  endtask : wr

  task automatic rdChk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string name);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk_sys);
    regRdStrobe <= 1'b0;
    #1;
    `CHK(name, e, regRdData & m)
  endtask : rdChk

  task automatic irqChk(input logic e);
    // irq follows the registers combinationally; two edges of margin after the write lands
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("irq", e, irq)
  endtask : irqChk

  // Counts cycles while sclOe stays at lvl; a stuck level ends the run
  task automatic levelLen(input logic lvl, output int cnt);
    cnt = 0;
    #1;
    while (sclOe === lvl && cnt < 1000)
    begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    if (cnt >= 1000)
    begin
      nFail++;
      conclude();
    end
  endtask : levelLen

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nFail = 0;
    checks = 0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (resetOffs[i])
      rdChk(resetOffs[i], 8'hFF, 8'h00, "reset value");
    $display("test reset done");

    wr(two_wire_pkg::OFF_CONTROL_TWO, {7'h08, 1'b1});
    wr(two_wire_pkg::OFF_IRQ_ENABLE, 8'h01);
    wr(two_wire_pkg::OFF_CONTROL_ONE, 8'h4C);
    rdChk(two_wire_pkg::OFF_CONTROL_ONE, 8'hFF, 8'h44, "control_one");
    for (int i = 0; i < 5; i++)
    begin
      wr(two_wire_pkg::OFF_IRQ_CLEAR, 8'h07);
      wr(two_wire_pkg::OFF_BUS_STATUS, 8'h04);
      wr(two_wire_pkg::OFF_OWN_SLAVE_ADDRESS, ownTab[i]);
      rdChk(two_wire_pkg::OFF_OWN_SLAVE_ADDRESS, 8'hFF, ownTab[i], "own address");
      bus_peer_model_i.sendAddr(sentTab[i], ackd);
      `CHK("ack", hitTab[i], ackd)
      rdChk(two_wire_pkg::OFF_SERIAL_DATA, 8'hFF, sentTab[i], "serial data");
      rdChk(two_wire_pkg::OFF_BUS_STATUS, 8'h84, {1'b1, 4'h0, hitTab[i], 2'h0}, "match");
      rdChk(two_wire_pkg::OFF_IRQ_STATUS, 8'h07, {5'h00, 2'h3, hitTab[i]}, "hit");
      irqChk(hitTab[i]);
    end
    wr(two_wire_pkg::OFF_CONTROL_ONE, 8'h04);
    irqChk(1'b0);
    wr(two_wire_pkg::OFF_CONTROL_ONE, 8'h40);
    irqChk(1'b0);
    wr(two_wire_pkg::OFF_CONTROL_ONE, 8'h44);
    irqChk(1'b1);
    wr(two_wire_pkg::OFF_IRQ_CLEAR, 8'h01);
    irqChk(1'b0);
    $display("test slave done");

    for (int k = 0; k < 2; k++)
    begin
      div = (k == 0) ? 7'h08 : 7'h7F;
      wr(two_wire_pkg::OFF_CONTROL_TWO, {div, 1'b1});
      wr(two_wire_pkg::OFF_CONTROL_ONE, 8'h45);
      levelLen(1'b0, n);
      levelLen(1'b1, n);
      `CHK("scl low cycles", 2 * int'(div), n)
      levelLen(1'b0, n);
      `CHK("scl high cycles", 2 * int'(div), n)
      if (k == 1)
      begin
        // Stop at the end of a low level, then SDA one level later
        wr(two_wire_pkg::OFF_CONTROL_ONE, 8'h46);
        repeat (8 * int'(div)) @(posedge clk_sys);
        rdChk(two_wire_pkg::OFF_CONTROL_ONE, 8'hFF, 8'h44, "stop bit");
        rdChk(two_wire_pkg::OFF_BUS_STATUS, 8'h82, 8'h00, "own stop");
      end
      wr(two_wire_pkg::OFF_CONTROL_TWO, {div, 1'b0});
      rdChk(two_wire_pkg::OFF_CONTROL_ONE, 8'hFF, 8'h00, "control_one");
      rdChk(two_wire_pkg::OFF_BUS_STATUS, 8'hFF, 8'h00, "bus_status");
      rdChk(two_wire_pkg::OFF_CONTROL_STATUS, 8'hFF, 8'h00, "control_status");
      n = 0;
      repeat (300)
      begin
        @(posedge clk_sys);
        #1;
        if (sclOe !== 1'b0)
          n++;
      end
      `CHK("scl halted", 0, n)
    end
    $display("test master done");
    conclude();
  end
endmodule : two_wire_unit_test
